// file: common/dbl_pkg.sv
// Constants and types shared by the converter bank and its processor-side master
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------
package dbl_pkg;
	// ------------------------------------------------------------
	// Port addresses and select codes
	// ------------------------------------------------------------
	localparam logic [7:0] DBL_ADDR_LOW = 8'hb5;
	localparam logic [7:0] DBL_ADDR_HIGH = 8'hb6;
	localparam logic [7:0] DBL_ADDR_SEL = 8'hb7;
	localparam logic [7:0] DBL_ADDR_PWR = 8'hf1;
	localparam int DBL_PWR_CONV_BIT = 6;
	localparam logic [7:0] DBL_PWR_RESET = 8'h00;
	localparam logic [7:0] DBL_SEL_LAST_DATA = 8'h03;
	localparam logic [7:0] DBL_SEL_CTL01 = 8'h04;
	localparam logic [7:0] DBL_SEL_CTL23 = 8'h05;
	localparam logic [7:0] DBL_SEL_LOAD = 8'h06;
	localparam logic [7:0] DBL_SEL_RESET = 8'h00;
	// ------------------------------------------------------------
	// Control fields and reset values
	// ------------------------------------------------------------
	localparam int DBL_CTL_FLAG = 7;
	localparam int DBL_CTL_DETECT = 6;
	localparam int DBL_CTL_IDIS = 5;
	localparam int DBL_CTL_REF = 2;
	localparam int DBL_CTL_MODE = 0;
	localparam logic [7:0] DBL_CTL01_RESET = 8'h63;
	localparam logic [7:0] DBL_CTL23_RESET = 8'h03;
	localparam logic [7:0] DBL_LOAD_RESET = 8'h00;
	localparam logic [15:0] DBL_DATA_RESET = 16'h0000;
	localparam int DBL_OC_TICKS = 3;
	localparam int DBL_CHANNELS = 4;
	localparam int DBL_IDAC_CHANNELS = 2;
	// ------------------------------------------------------------
	// Modes and decode targets
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DBL_LD_DIRECT = 2'b00,
		DBL_LD_MS = 2'b01,
		DBL_LD_HMS = 2'b10,
		DBL_LD_SYNC = 2'b11
	} dbl_load_t;
	typedef enum logic [1:0] {
		DBL_OM_NORMAL = 2'b00,
		DBL_OM_1K = 2'b01,
		DBL_OM_100K = 2'b10,
		DBL_OM_HIZ = 2'b11
	} dbl_omode_t;
	typedef enum logic [2:0] {
		DBL_T_DATA = 3'b000,
		DBL_T_CTL01 = 3'b001,
		DBL_T_CTL23 = 3'b010,
		DBL_T_LOAD = 3'b011,
		DBL_T_NONE = 3'b100
	} dbl_target_t;
	typedef logic [3:0][15:0] dbl_codes_t;
	typedef logic [3:0][1:0] dbl_modes_t;
	// ------------------------------------------------------------
	// Master APB map
	// ------------------------------------------------------------
	localparam logic [11:0] DBL_APB_CMD = 12'h000;
	localparam logic [11:0] DBL_APB_STAT = 12'h004;
	localparam int DBL_CMD_DATA_LSB = 0;
	localparam int DBL_CMD_ADDR_LSB = 8;
	localparam int DBL_CMD_WRITE = 16;
	localparam int DBL_STAT_BUSY = 0;
	localparam int DBL_STAT_DATA_LSB = 8;
endpackage

// file: common/dbl_sfr_if.sv
// Special-function register link between processor master and converter bank
`timescale 1ns/100ps
interface dbl_sfr_if (
	input logic pclk, // Shared clock
	input logic presetn // Shared reset, active low
);
	logic [7:0] addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic pd_conv;
	modport device (input addr, input wr, input rd, input wdata, input pd_conv, output rdata);
	modport host (output addr, output wr, output rd, output wdata, output pd_conv, input rdata);
endinterface // dbl_sfr_if

// file: rtl/dbl_oc_guard.sv
// Over-current qualification and latched shutdown for one current output
`timescale 1ns/100ps
module dbl_oc_guard #(
	parameter int TICKS = dbl_pkg::DBL_OC_TICKS
) (
	input logic pclk, // Clock
	input logic presetn, // Async reset, active low
	input logic over_current, // Synchronised condition level
	input logic detect_en, // Detection enable
	input logic ms_tick, // Millisecond tick pulse
	input logic clear_req, // Zero written to flag
	output logic flag, // Over-range flag readback
	output logic shutdown // Outputs forced off
);
	import dbl_pkg::*;
	localparam int CW = $clog2(TICKS + 1);
	logic [CW-1:0] cnt_q, cnt_d;
	logic trip_q, trip_d;
	logic set;

	always_comb begin
		cnt_d = cnt_q;
		trip_d = trip_q;
		if (!over_current || !detect_en) begin
			cnt_d = '0;
		end else if (ms_tick && cnt_q != CW'(TICKS)) begin
			cnt_d = cnt_q + CW'(1);
		end
		set = (cnt_d == CW'(TICKS));
		// Clear refused while condition persists
		if (clear_req && !over_current) begin
			trip_d = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (set) begin
			trip_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			trip_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			trip_q <= trip_d;
		end
	end

	assign flag = detect_en ? trip_q : (trip_q | over_current);
	assign shutdown = trip_q;
endmodule // dbl_oc_guard

// file: rtl/dbl_dac_bank.sv
// Converter bank end: indirect ports, buffers, load modes and output control
//
// The special-function register port was chosen for this implementation.
`timescale 1ns/100ps
module dbl_dac_bank (
	input logic pclk, // Processor clock
	input logic presetn, // Async reset, active low
	dbl_sfr_if.device sfr, // Special-function register link
	input logic millisecond_tick, // One-cycle tick
	input logic hundred_ms_tick, // One-cycle tick
	input logic [1:0] over_current_raw, // Comparator levels, asynchronous
	output dbl_pkg::dbl_codes_t dac_code, // Output registers
	output logic [3:0] reference_select, // 1 selects reference pin
	output dbl_pkg::dbl_modes_t output_mode, // Stored output modes
	output logic [3:0] voltage_enable, // Voltage output driving
	output logic [1:0] current_enable // Current output driving
);
	import dbl_pkg::*;

	// ------------------------------------------------------------
	// Select decode
	// ------------------------------------------------------------
	function automatic dbl_target_t target_of(input logic [7:0] sel);
		if (sel <= DBL_SEL_LAST_DATA) begin
			target_of = DBL_T_DATA;
		end else if (sel == DBL_SEL_CTL01) begin
			target_of = DBL_T_CTL01;
		end else if (sel == DBL_SEL_CTL23) begin
			target_of = DBL_T_CTL23;
		end else if (sel == DBL_SEL_LOAD) begin
			target_of = DBL_T_LOAD;
		end else begin
			target_of = DBL_T_NONE;
		end
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] sel_q, sel_d;
	dbl_codes_t buf_q, buf_d;
	dbl_codes_t out_q, out_d;
	logic [7:0] load_q, load_d;
	logic [3:0] ref_q, ref_d;
	dbl_modes_t mode_q, mode_d;
	logic [1:0] det_q, det_d;
	logic [1:0] idis_q, idis_d;
	logic [7:0] rdata_q, rdata_d;
	logic [1:0] oc_s1_q, oc_s2_q, oc_s3_q;
	logic [1:0] oc_q, oc_d;
	logic [1:0] clr_req;
	logic [1:0] flag;
	logic [1:0] shutdown;
	logic [3:0] shut4;
	logic wr_ok, wr_low, wr_high, wr_sel;
	dbl_target_t tgt;
	logic [1:0] ch_sel;
	logic [7:0] rd_low, rd_high;

	assign wr_ok = sfr.wr & ~sfr.pd_conv;
	assign wr_low = wr_ok && sfr.addr == DBL_ADDR_LOW;
	assign wr_high = wr_ok && sfr.addr == DBL_ADDR_HIGH;
	assign wr_sel = wr_ok && sfr.addr == DBL_ADDR_SEL;
	assign tgt = target_of(sel_q);
	assign ch_sel = sel_q[1:0];

	// ------------------------------------------------------------
	// Over-current qualification
	// ------------------------------------------------------------
	always_comb begin
		oc_d = oc_q;
		// Change taken once the later two stages agree
		for (int i = 0; i < DBL_IDAC_CHANNELS; i++) begin
			if (oc_s2_q[i] == oc_s3_q[i]) begin
				oc_d[i] = oc_s2_q[i];
			end
		end
		clr_req = '0;
		if (tgt == DBL_T_CTL01 && !sfr.wdata[DBL_CTL_FLAG]) begin
			clr_req[0] = wr_low;
			clr_req[1] = wr_high;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oc_s1_q <= '0;
			oc_s2_q <= '0;
			oc_s3_q <= '0;
			oc_q <= '0;
		end else begin
			oc_s1_q <= over_current_raw;
			oc_s2_q <= oc_s1_q;
			oc_s3_q <= oc_s2_q;
			oc_q <= oc_d;
		end
	end

	for (genvar g = 0; g < DBL_IDAC_CHANNELS; g++) begin : g_guard
		dbl_oc_guard #(
			.TICKS(DBL_OC_TICKS)
		) u_guard (
			.pclk(pclk),
			.presetn(presetn),
			.over_current(oc_q[g]),
			.detect_en(det_q[g]),
			.ms_tick(millisecond_tick),
			.clear_req(clr_req[g]),
			.flag(flag[g]),
			.shutdown(shutdown[g])
		);
	end

	// ------------------------------------------------------------
	// Register writes and output loading
	// ------------------------------------------------------------
	always_comb begin
		sel_d = sel_q;
		buf_d = buf_q;
		out_d = out_q;
		load_d = load_q;
		ref_d = ref_q;
		mode_d = mode_q;
		det_d = det_q;
		idis_d = idis_q;
		if (wr_sel) begin
			sel_d = sfr.wdata;
		end
		unique case (tgt)
			DBL_T_DATA: begin
				if (wr_high) begin
					buf_d[ch_sel][15:8] = sfr.wdata;
				end
				if (wr_low) begin
					buf_d[ch_sel][7:0] = sfr.wdata;
				end
			end
			DBL_T_CTL01: begin
				// Flag bit is not stored; shutdown lives in the guard
				if (wr_low) begin
					det_d[0] = sfr.wdata[DBL_CTL_DETECT];
					idis_d[0] = sfr.wdata[DBL_CTL_IDIS];
					ref_d[0] = sfr.wdata[DBL_CTL_REF];
					mode_d[0] = sfr.wdata[DBL_CTL_MODE +: 2];
				end
				if (wr_high) begin
					det_d[1] = sfr.wdata[DBL_CTL_DETECT];
					idis_d[1] = sfr.wdata[DBL_CTL_IDIS];
					ref_d[1] = sfr.wdata[DBL_CTL_REF];
					mode_d[1] = sfr.wdata[DBL_CTL_MODE +: 2];
				end
			end
			DBL_T_CTL23: begin
				if (wr_low) begin
					ref_d[2] = sfr.wdata[DBL_CTL_REF];
					mode_d[2] = sfr.wdata[DBL_CTL_MODE +: 2];
				end
				if (wr_high) begin
					ref_d[3] = sfr.wdata[DBL_CTL_REF];
					mode_d[3] = sfr.wdata[DBL_CTL_MODE +: 2];
				end
			end
			DBL_T_LOAD: begin
				if (wr_low) begin
					load_d = sfr.wdata;
				end
			end
			DBL_T_NONE: begin
				// Writes dropped
			end
		endcase
		// Buffer value of this cycle is used; a same-cycle tick takes the old one
		for (int c = 0; c < DBL_CHANNELS; c++) begin
			unique case (dbl_load_t'(load_q[2*c +: 2]))
				DBL_LD_DIRECT: begin
					if (tgt == DBL_T_DATA && ch_sel == 2'(c) && wr_low) begin
						out_d[c] = {buf_q[c][15:8], sfr.wdata};
					end
				end
				DBL_LD_MS: begin
					if (millisecond_tick) begin
						out_d[c] = buf_q[c];
					end
				end
				DBL_LD_HMS: begin
					if (hundred_ms_tick) begin
						out_d[c] = buf_q[c];
					end
				end
				DBL_LD_SYNC: begin
				end
			endcase
			if (tgt == DBL_T_LOAD && wr_low && dbl_load_t'(sfr.wdata[2*c +: 2]) == DBL_LD_SYNC) begin
				out_d[c] = buf_q[c];
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	always_comb begin
		rd_low = '0;
		rd_high = '0;
		unique case (tgt)
			DBL_T_DATA: begin
				rd_low = buf_q[ch_sel][7:0];
				rd_high = buf_q[ch_sel][15:8];
			end
			DBL_T_CTL01: begin
				rd_low = {flag[0], det_q[0], idis_q[0], 2'b00, ref_q[0], mode_q[0]};
				rd_high = {flag[1], det_q[1], idis_q[1], 2'b00, ref_q[1], mode_q[1]};
			end
			DBL_T_CTL23: begin
				rd_low = {5'h00, ref_q[2], mode_q[2]};
				rd_high = {5'h00, ref_q[3], mode_q[3]};
			end
			DBL_T_LOAD: begin
				rd_low = load_q;
			end
			DBL_T_NONE: begin
			end
		endcase
		rdata_d = rdata_q;
		if (sfr.rd) begin
			if (sfr.addr == DBL_ADDR_SEL) begin
				rdata_d = sel_q;
			end else if (sfr.addr == DBL_ADDR_HIGH) begin
				rdata_d = rd_high;
			end else if (sfr.addr == DBL_ADDR_LOW) begin
				rdata_d = rd_low;
			end else begin
				rdata_d = '0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= DBL_SEL_RESET;
			buf_q <= {DBL_CHANNELS{DBL_DATA_RESET}};
			out_q <= {DBL_CHANNELS{DBL_DATA_RESET}};
			load_q <= DBL_LOAD_RESET;
			ref_q <= {DBL_CTL23_RESET[DBL_CTL_REF], DBL_CTL23_RESET[DBL_CTL_REF],
				DBL_CTL01_RESET[DBL_CTL_REF], DBL_CTL01_RESET[DBL_CTL_REF]};
			mode_q <= {DBL_CTL23_RESET[DBL_CTL_MODE +: 2], DBL_CTL23_RESET[DBL_CTL_MODE +: 2],
				DBL_CTL01_RESET[DBL_CTL_MODE +: 2], DBL_CTL01_RESET[DBL_CTL_MODE +: 2]};
			det_q <= {2{DBL_CTL01_RESET[DBL_CTL_DETECT]}};
			idis_q <= {2{DBL_CTL01_RESET[DBL_CTL_IDIS]}};
			rdata_q <= '0;
		end else begin
			sel_q <= sel_d;
			buf_q <= buf_d;
			out_q <= out_d;
			load_q <= load_d;
			ref_q <= ref_d;
			mode_q <= mode_d;
			det_q <= det_d;
			idis_q <= idis_d;
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign sfr.rdata = rdata_q;
	assign dac_code = out_q;
	assign reference_select = ref_q;
	assign output_mode = mode_q;
	assign shut4 = {2'b00, shutdown};
	for (genvar v = 0; v < DBL_CHANNELS; v++) begin : g_vout
		assign voltage_enable[v] = mode_q[v] == DBL_OM_NORMAL && !shut4[v];
	end
	for (genvar k = 0; k < DBL_IDAC_CHANNELS; k++) begin : g_iout
		assign current_enable[k] = mode_q[k] == DBL_OM_NORMAL && !idis_q[k] && !shutdown[k];
	end
endmodule // dbl_dac_bank

// file: rtl/dbl_sfr_master.sv
// Processor end: APB-commanded special-function register accesses and power control
`timescale 1ns/100ps
module dbl_sfr_master (
	input logic pclk, // Clock
	input logic presetn, // Async reset, active low
	input logic [11:0] paddr, // APB address
	input logic psel, // APB select
	input logic penable, // APB enable
	input logic pwrite, // APB direction
	input logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	dbl_sfr_if.host sfr // Special-function register link
);
	import dbl_pkg::*;
	typedef enum logic [1:0] {
		DBL_M_IDLE = 2'b00,
		DBL_M_STROBE = 2'b01,
		DBL_M_CATCH = 2'b10
	} dbl_mstate_t;

	dbl_mstate_t st_q, st_d;
	logic [7:0] addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d;
	logic is_wr_q, is_wr_d;
	logic [7:0] rd_q, rd_d;
	logic [7:0] pwr_q, pwr_d;
	logic [31:0] prdata_q, prdata_d;
	logic mapped, setup, access, cmd_wr;

	assign mapped = paddr == DBL_APB_CMD || paddr == DBL_APB_STAT;
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign cmd_wr = access && pwrite && paddr == DBL_APB_CMD;

	always_comb begin
		st_d = st_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		is_wr_d = is_wr_q;
		rd_d = rd_q;
		pwr_d = pwr_q;
		prdata_d = prdata_q;
		if (setup) begin
			prdata_d = '0;
			if (paddr == DBL_APB_STAT) begin
				prdata_d[DBL_STAT_BUSY] = st_q != DBL_M_IDLE;
				prdata_d[DBL_STAT_DATA_LSB +: 8] = rd_q;
			end
		end
		unique case (st_q)
			DBL_M_IDLE: begin
				// Commands arriving while busy are dropped
				if (cmd_wr) begin
					addr_d = pwdata[DBL_CMD_ADDR_LSB +: 8];
					wdata_d = pwdata[DBL_CMD_DATA_LSB +: 8];
					is_wr_d = pwdata[DBL_CMD_WRITE];
					if (pwdata[DBL_CMD_ADDR_LSB +: 8] == DBL_ADDR_PWR) begin
						// Power register lives on this side
						if (pwdata[DBL_CMD_WRITE]) begin
							pwr_d = pwdata[DBL_CMD_DATA_LSB +: 8];
						end else begin
							rd_d = pwr_q;
						end
					end else begin
						st_d = DBL_M_STROBE;
					end
				end
			end
			DBL_M_STROBE: begin
				st_d = is_wr_q ? DBL_M_IDLE : DBL_M_CATCH;
			end
			DBL_M_CATCH: begin
				rd_d = sfr.rdata;
				st_d = DBL_M_IDLE;
			end
			default: begin
				st_d = DBL_M_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= DBL_M_IDLE;
			addr_q <= '0;
			wdata_q <= '0;
			is_wr_q <= 1'b0;
			rd_q <= '0;
			pwr_q <= DBL_PWR_RESET;
			prdata_q <= '0;
		end else begin
			st_q <= st_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			is_wr_q <= is_wr_d;
			rd_q <= rd_d;
			pwr_q <= pwr_d;
			prdata_q <= prdata_d;
		end
	end

	assign sfr.addr = addr_q;
	assign sfr.wdata = wdata_q;
	assign sfr.wr = st_q == DBL_M_STROBE && is_wr_q;
	assign sfr.rd = st_q == DBL_M_STROBE && !is_wr_q;
	assign sfr.pd_conv = pwr_q[DBL_PWR_CONV_BIT];
	assign prdata = prdata_q;
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
endmodule // dbl_sfr_master

// file: bench/dbl_link_asserts.sv
// Checker for the register link between the two ends and the converter bank outputs
`timescale 1ns/100ps
module dbl_link_asserts (
	input logic pclk, // Clock
	input logic presetn, // Reset, active low
	input logic [7:0] addr, // Register address
	input logic wr, // Write strobe
	input logic rd, // Read strobe
	input logic [7:0] wdata, // Write data
	input logic [7:0] rdata, // Read data
	input logic pd_conv, // Converter power-down
	input logic millisecond_tick, // Short tick
	input logic hundred_ms_tick, // Long tick
	input dbl_pkg::dbl_codes_t dac_code, // Output registers
	input dbl_pkg::dbl_modes_t output_mode, // Stored output modes
	input logic [3:0] voltage_enable, // Voltage outputs on
	input logic [1:0] current_enable // Current outputs on
);
	import dbl_pkg::*;
	// ------------------------------------------------------------
	// Shadow of select and load control
	// ------------------------------------------------------------
	logic [7:0] sel_q, sel_d, load_q, load_d;
	logic wr_ok, low_hit, high_hit;
	assign wr_ok = wr && !pd_conv;
	assign low_hit = wr_ok && addr == DBL_ADDR_LOW && sel_q <= DBL_SEL_LAST_DATA && load_q[{sel_q[1:0], 1'b0} +: 2] == 2'b00;
	assign high_hit = wr_ok && addr == DBL_ADDR_HIGH && sel_q <= DBL_SEL_LAST_DATA && load_q[{sel_q[1:0], 1'b0} +: 2] == 2'b00;
	always_comb begin
		sel_d = sel_q;
		load_d = load_q;
		if (wr_ok && addr == DBL_ADDR_SEL)
			sel_d = wdata;
		if (wr_ok && addr == DBL_ADDR_LOW && sel_q == DBL_SEL_LOAD)
			load_d = wdata;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q <= DBL_SEL_RESET;
			load_q <= DBL_LOAD_RESET;
		end else begin
			sel_q <= sel_d;
			load_q <= load_d;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_wr_pulse;
		wr |=> !wr;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe held over one cycle");
	property p_low_load;
		low_hit |=> dac_code[$past(sel_q[1:0])][7:0] == $past(wdata);
	endproperty
	a_low_load: assert property (p_low_load) else $error("low write did not reach output");
	property p_high_hold;
		high_hit |=> dac_code[$past(sel_q[1:0])] == $past(dac_code[sel_q[1:0]]);
	endproperty
	a_high_hold: assert property (p_high_hold) else $error("high write changed output");
	property p_ms_only;
		(load_q[1:0] == 2'b01 && $past(load_q[1:0]) == 2'b01 && dac_code[0] != $past(dac_code[0])) |-> $past(millisecond_tick);
	endproperty
	a_ms_only: assert property (p_ms_only) else $error("channel 0 loaded without short tick");
	property p_hms_only;
		(load_q[3:2] == 2'b10 && $past(load_q[3:2]) == 2'b10 && dac_code[1] != $past(dac_code[1])) |-> $past(hundred_ms_tick);
	endproperty
	a_hms_only: assert property (p_hms_only) else $error("channel 1 loaded without long tick");
	property p_pd_block;
		pd_conv && wr |=> $stable(output_mode);
	endproperty
	a_pd_block: assert property (p_pd_block) else $error("write taken while powered down");
	property p_rsv_read;
		rd && (addr == DBL_ADDR_LOW || addr == DBL_ADDR_HIGH) && (sel_q > DBL_SEL_LOAD || (sel_q == DBL_SEL_LOAD && addr == DBL_ADDR_HIGH)) |=> rdata == 8'h00;
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("reserved read not zero");
	property p_load_read;
		rd && addr == DBL_ADDR_LOW && sel_q == DBL_SEL_LOAD |=> rdata == $past(load_q);
	endproperty
	a_load_read: assert property (p_load_read) else $error("load control readback wrong");
	property p_cur_mode;
		current_enable[0] |-> voltage_enable[0] && output_mode[0] == 2'b00;
	endproperty
	a_cur_mode: assert property (p_cur_mode) else $error("current output on outside normal mode");
	property p_volt_mode;
		voltage_enable[3:2] == {output_mode[3] == 2'b00, output_mode[2] == 2'b00};
	endproperty
	a_volt_mode: assert property (p_volt_mode) else $error("voltage enable disagrees with mode");
endmodule // dbl_link_asserts

// file: bench/tb_top.sv
// Testbench joining processor end and converter bank, driven over APB
`timescale 1ns/100ps
module tb_top;
	import dbl_pkg::*;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic ms_tick = 1'b0, hms_tick = 1'b0;
	logic [1:0] oc_raw = 2'b00, current_enable;
	logic [3:0] reference_select, voltage_enable;
	dbl_codes_t dac_code;
	dbl_modes_t output_mode;
	int n_mismatch = 0, num_checks = 0;
	dbl_sfr_if sfr_link (.pclk(pclk), .presetn(presetn));
	dbl_sfr_master i_dbl_sfr_master (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sfr(sfr_link));
	dbl_dac_bank i_dbl_dac_bank (.pclk(pclk), .presetn(presetn), .sfr(sfr_link), .millisecond_tick(ms_tick),
		.hundred_ms_tick(hms_tick), .over_current_raw(oc_raw), .dac_code(dac_code), .reference_select(reference_select),
		.output_mode(output_mode), .voltage_enable(voltage_enable), .current_enable(current_enable));
	dbl_link_asserts i_dbl_link_asserts (.pclk(pclk), .presetn(presetn), .addr(sfr_link.addr), .wr(sfr_link.wr),
		.rd(sfr_link.rd), .wdata(sfr_link.wdata), .rdata(sfr_link.rdata), .pd_conv(sfr_link.pd_conv),
		.millisecond_tick(ms_tick), .hundred_ms_tick(hms_tick), .dac_code(dac_code), .output_mode(output_mode),
		.voltage_enable(voltage_enable), .current_enable(current_enable));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (pready !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Polls busy so the next order never lands on a running access
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		logic [31:0] r;
		logic e;
		int i;
		apb(1'b1, DBL_APB_CMD, {15'h0, w, a, d}, r, e);
		for (i = 0; i < 20; i++) begin
			apb(1'b0, DBL_APB_STAT, 32'h0, r, e);
			if (r[DBL_STAT_BUSY] === 1'b0)
				break;
		end
		if (r[DBL_STAT_BUSY] !== 1'b0) begin
			n_mismatch++;
			finish_test();
		end
		q = r[15:8];
	endtask
	task automatic wr8(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		sfr(1'b1, a, d, q);
	endtask
	task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		sfr(1'b0, a, 8'h00, q);
		chk(name, {8'h00, exp}, {8'h00, q});
	endtask
	task automatic tick(input logic h);
		@(posedge pclk);
		ms_tick <= !h;
		hms_tick <= h;
		@(posedge pclk);
		ms_tick <= 1'b0;
		hms_tick <= 1'b0;
		@(posedge pclk);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk("venable", 16'h0000, 16'(voltage_enable));
		wr8(DBL_ADDR_SEL, DBL_SEL_CTL01);
		rdchk("ctl0", DBL_ADDR_LOW, DBL_CTL01_RESET);
		rdchk("ctl1", DBL_ADDR_HIGH, DBL_CTL01_RESET);
		wr8(DBL_ADDR_SEL, DBL_SEL_CTL23);
		rdchk("ctl2", DBL_ADDR_LOW, DBL_CTL23_RESET);
		rdchk("ctl3", DBL_ADDR_HIGH, DBL_CTL23_RESET);
		wr8(DBL_ADDR_SEL, DBL_SEL_LOAD);
		rdchk("load", DBL_ADDR_LOW, DBL_LOAD_RESET);
	endtask
	task automatic t_direct();
		logic [15:0] v;
		for (int c = 0; c < 4; c++) begin
			v = {8'hc1 + 8'(c), 8'h47 + 8'(c)};
			wr8(DBL_ADDR_SEL, 8'(c));
			wr8(DBL_ADDR_HIGH, v[15:8]);
			chk("code_hold", DBL_DATA_RESET, dac_code[c]);
			wr8(DBL_ADDR_LOW, v[7:0]);
			chk("code_load", v, dac_code[c]);
			rdchk("buf_low", DBL_ADDR_LOW, v[7:0]);
		end
	endtask
	task automatic t_tick();
		wr8(DBL_ADDR_SEL, DBL_SEL_LOAD);
		wr8(DBL_ADDR_LOW, 8'h09);
		wr8(DBL_ADDR_SEL, 8'h00);
		wr8(DBL_ADDR_HIGH, 8'ha5);
		wr8(DBL_ADDR_LOW, 8'ha5);
		wr8(DBL_ADDR_SEL, 8'h01);
		wr8(DBL_ADDR_HIGH, 8'h5a);
		wr8(DBL_ADDR_LOW, 8'h5a);
		chk("hms_wait", 16'hc248, dac_code[1]);
		tick(1'b1);
		chk("hms_load", 16'h5a5a, dac_code[1]);
		chk("ms_wait", 16'hc147, dac_code[0]);
		tick(1'b0);
		chk("ms_load", 16'ha5a5, dac_code[0]);
	endtask
	task automatic t_sync();
		wr8(DBL_ADDR_SEL, DBL_SEL_LOAD);
		wr8(DBL_ADDR_LOW, 8'hfc);
		for (int c = 1; c < 4; c++) begin
			wr8(DBL_ADDR_SEL, 8'(c));
			wr8(DBL_ADDR_HIGH, 8'h20 + 8'(c));
			wr8(DBL_ADDR_LOW, 8'h30 + 8'(c));
		end
		chk("sync_hold", 16'hc44a, dac_code[3]);
		wr8(DBL_ADDR_SEL, DBL_SEL_LOAD);
		wr8(DBL_ADDR_LOW, 8'hfc);
		for (int c = 1; c < 4; c++)
			chk("sync_load", {8'h20 + 8'(c), 8'h30 + 8'(c)}, dac_code[c]);
	endtask
	task automatic t_ctl();
		wr8(DBL_ADDR_SEL, DBL_SEL_CTL01);
		for (int m = 0; m < 4; m++) begin
			wr8(DBL_ADDR_LOW, 8'h04 | 8'(m));
			chk("mode", 16'(m), 16'(output_mode[0]));
			chk("venable", 16'(m == 0), 16'(voltage_enable[0]));
			chk("cenable", 16'(m == 0), 16'(current_enable[0]));
			chk("refsel", 16'h0001, 16'(reference_select[0]));
		end
		wr8(DBL_ADDR_LOW, 8'h20);
		chk("cen_off", 16'h0000, 16'(current_enable[0]));
		chk("ven_on", 16'h0001, 16'(voltage_enable[0]));
		chk("refsel", 16'h0000, 16'(reference_select[0]));
		rdchk("ctl0", DBL_ADDR_LOW, 8'h20);
		wr8(DBL_ADDR_HIGH, 8'hdf);
		rdchk("ctl1", DBL_ADDR_HIGH, 8'h47);
		wr8(DBL_ADDR_SEL, DBL_SEL_CTL23);
		wr8(DBL_ADDR_LOW, 8'hff);
		rdchk("ctl2", DBL_ADDR_LOW, 8'h07);
		wr8(DBL_ADDR_LOW, 8'h00);
		chk("ven2", 16'h0001, 16'(voltage_enable[2]));
	endtask
	task automatic t_oc();
		wr8(DBL_ADDR_SEL, DBL_SEL_CTL01);
		wr8(DBL_ADDR_LOW, 8'h40);
		wr8(DBL_ADDR_HIGH, 8'h40);
		oc_raw <= 2'b11;
		repeat (8) @(posedge pclk);
		tick(1'b0);
		tick(1'b0);
		chk("oc_wait", 16'h0003, 16'(voltage_enable[1:0]));
		tick(1'b0);
		chk("oc_ven", 16'h0000, 16'(voltage_enable[1:0]));
		chk("oc_cen", 16'h0000, 16'(current_enable));
		chk("oc_mode", 16'h0000, 16'(output_mode[1:0]));
		rdchk("oc_flag", DBL_ADDR_LOW, 8'hc0);
		rdchk("oc_flag1", DBL_ADDR_HIGH, 8'hc0);
		wr8(DBL_ADDR_LOW, 8'h40);
		chk("oc_stuck", 16'h0000, 16'(voltage_enable[1:0]));
		oc_raw <= 2'b00;
		repeat (8) @(posedge pclk);
		wr8(DBL_ADDR_LOW, 8'h40);
		chk("oc_free", 16'h0001, 16'(current_enable));
		wr8(DBL_ADDR_HIGH, 8'h40);
		chk("oc_free1", 16'h0003, 16'(current_enable));
		wr8(DBL_ADDR_LOW, 8'h00);
		oc_raw <= 2'b01;
		repeat (8) @(posedge pclk);
		rdchk("oc_direct", DBL_ADDR_LOW, 8'h80);
		oc_raw <= 2'b00;
	endtask
	task automatic t_power();
		logic [31:0] r;
		logic e;
		wr8(DBL_ADDR_PWR, 8'h40);
		wr8(DBL_ADDR_LOW, 8'h03);
		chk("pd_mode", 16'h0000, 16'(output_mode[0]));
		wr8(DBL_ADDR_PWR, DBL_PWR_RESET);
		wr8(DBL_ADDR_SEL, 8'h07);
		wr8(DBL_ADDR_LOW, 8'h55);
		rdchk("rsv_low", DBL_ADDR_LOW, 8'h00);
		rdchk("rsv_high", DBL_ADDR_HIGH, 8'h00);
		wr8(DBL_ADDR_SEL, DBL_SEL_LOAD);
		wr8(DBL_ADDR_HIGH, 8'h33);
		rdchk("load_high", DBL_ADDR_HIGH, 8'h00);
		rdchk("load_keep", DBL_ADDR_LOW, 8'hfc);
		apb(1'b0, 12'h008, 32'h0, r, e);
		chk("slverr", 16'h0001, 16'(e));
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_direct();
		t_tick();
		t_sync();
		t_ctl();
		t_oc();
		t_power();
		finish_test();
	end
endmodule // tb_top
